// File: rtl/cid_defines.svh
/*
 * Constants of the compact instruction decoder: major codes, minor codes,
 * field positions and state codes.
 * Assumes inclusion by bare name from the rtl/ folder.
 */
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH

`define CID_HALF_W       16
`define CID_OP_HI        15
`define CID_OP_LO        11
`define CID_R1_HI        10
`define CID_R1_LO        8
`define CID_R2_HI        7
`define CID_R2_LO        5
`define CID_R3_HI        4
`define CID_R3_LO        2

`define CID_OP_JAL       5'h03
`define CID_OP_SHIFT     5'h06
`define CID_OP_ADDI      5'h08
`define CID_OP_I8        5'h0c
`define CID_OP_RRR       5'h1c
`define CID_OP_RR        5'h1d
`define CID_OP_PREFIX    5'h1e
`define CID_OP_I64       5'h1f
`define CID_OP_BRANCH    5'h02
`define CID_OP_LD        5'h07
`define CID_OP_SD        5'h0f
`define CID_OP_LWSP      5'h12
`define CID_OP_LWPC      5'h16
`define CID_OP_SWSP      5'h1a
`define CID_OP_RRR_LO    5'h18

`define CID_RR_JUMP      5'h00
`define CID_RR_DSRL      5'h08
`define CID_RR_DSRA      5'h13
`define CID_RR_RSV0      5'h01
`define CID_RR_RSV1      5'h11
`define CID_RR_RSV2      5'h15
`define CID_JR_RX        3'h0
`define CID_JR_RA        3'h1
`define CID_JALR_RA      3'h2
`define CID_I8_RSV0      3'h4
`define CID_I8_RSV1      3'h6
`define CID_I64_ADD5     3'h5
`define CID_I64_ADDPC    3'h6
`define CID_SH_DSLL      2'h1

`define CID_W_NONE       5'h00
`define CID_W_RRIA       5'h04
`define CID_W_RRI        5'h05
`define CID_W_RI         5'h08
`define CID_W_I          5'h0b
`define CID_W_EXT_RRIA   5'h0f
`define CID_W_EXT        5'h10
`define CID_SHIFT_ZERO   6'h08

`define CID_ST_IDLE      3'b001
`define CID_ST_PREFIX    3'b010
`define CID_ST_JAL2      3'b100

`endif

// File: rtl/cid_pkg.sv
/*
 * Types of the compact instruction decoder.
 * Assumes cid_defines.svh for the state codes.
 */
`include "cid_defines.svh"

package cid_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = `CID_ST_IDLE,
        ST_PREFIX = `CID_ST_PREFIX,
        ST_JAL2   = `CID_ST_JAL2
    } state_type;

    typedef enum logic [3:0] {
        GRP_OTHER = 4'h0,
        GRP_JAL   = 4'h1,
        GRP_SHIFT = 4'h2,
        GRP_ADDI  = 4'h3,
        GRP_I8    = 4'h4,
        GRP_RRR   = 4'h5,
        GRP_RR    = 4'h6,
        GRP_I64   = 4'h7
    } group_type;
endpackage

// File: rtl/field_if.sv
/*
 * Carrier of the raw fields of one halfword between the splitter and the
 * decoder core. Purely combinational, no clock.
 */
`timescale 1ns/1ps

interface field_if;
    logic [4:0]  major;
    logic [2:0]  first_reg;
    logic [2:0]  second_reg_field;
    logic [2:0]  third_reg_field;
    logic [4:0]  func5;
    logic [1:0]  func2;
    logic [10:0] imm11;

    modport src (output major, first_reg, second_reg_field, third_reg_field,
                 func5, func2, imm11);
    modport dst (input  major, first_reg, second_reg_field, third_reg_field,
                 func5, func2, imm11);
endinterface

// File: rtl/field_split.sv
/*
 * Splits one 16-bit halfword into its fixed fields.
 * Assumes the halfword is stable for the cycle; no state.
 */
`timescale 1ns/1ps
`include "cid_defines.svh"

module field_split (
    input  wire logic [15:0] i_half,
    field_if.src             f
);
    assign f.major            = i_half[`CID_OP_HI:`CID_OP_LO];
    assign f.first_reg        = i_half[`CID_R1_HI:`CID_R1_LO];
    assign f.second_reg_field = i_half[`CID_R2_HI:`CID_R2_LO];
    assign f.third_reg_field  = i_half[`CID_R3_HI:`CID_R3_LO];
    assign f.func5            = i_half[4:0];
    assign f.func2            = i_half[1:0];
    assign f.imm11            = i_half[10:0];
endmodule

// File: rtl/compact_isa_decoder.sv
/*
 * Decoder of the compact 16-bit instruction set with prefix and long jump.
 * Assumes fetch hands over one halfword per i_valid cycle in program order
 * and that i_mode64 is a level from logic on the same clock.
 */
// Behaviour
// - Accept 16-bit halfword-aligned instructions, one per valid cycle.
// - Long jump and prefixed instructions decode as one 32-bit unit.
// - Major code is bits 15:11; 15:14 row, 13:11 column.
// - Three register fields, each 3 bits, from the compact subset.
// - Unextended immediate is 4, 5, 8 or 11 bits by format.
// - Major map: long jump, shift, add, eight-bit, three-reg, two-reg, prefix, doubleword.
// - Two-register group uses function bits 4:0; 4:3 row, 2:0 column.
// - Register jump qualified by second field: 000, 001 with first 000, 010.
// - Doubleword right shifts count from first field, 0 is 8; only they extend.
// - Unassigned minor codes raise the reserved instruction flag.
// - Three-register bits 1:0: doubleword add, add, doubleword sub, sub.
// - Shift bits 1:0: left, doubleword left, right logical, right arithmetic.
// - Unextended shift count 0 means 8; extended counts are not remapped.
// - Extended count top bit used only for doubleword shifts, left and right.
// - Eight-bit group bits 10:8 select branches, store, adjust, full moves.
// - Move from full register carries a 5-bit register number in 4:0.
// - Doubleword group bits 10:8 select op; valid only in 64-bit mode.
// - Prefixed immediate: 15:11 prefix low, 10:5 prefix middle, 4:0 own.
// - Long jump target 25:21, 20:16 first half, 15:0 second; exchange bit.
`timescale 1ns/1ps
`include "cid_defines.svh"

module compact_isa_decoder
    import cid_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_valid,
    input  wire logic [15:0] i_half,
    input  wire logic        i_mode64,
    output logic             o_valid,
    output group_type        o_group,
    output logic [4:0]       o_major_code,
    output logic [4:0]       o_minor,
    output logic [2:0]       o_first_reg,
    output logic [2:0]       o_second_reg_field,
    output logic [2:0]       o_third_reg_field,
    output logic [4:0]       o_full_register_number,
    output logic [15:0]      o_imm,
    output logic [4:0]       o_imm_bits,
    output logic [5:0]       o_shamt,
    output logic             o_extended,
    output logic             o_is32,
    output logic [25:0]      o_target,
    output logic             o_exchange,
    output logic             o_reserved
);
    field_if f ();

    field_split u_split (
        .i_half (i_half),
        .f      (f)
    );

    // Width of the unextended immediate field of a format
    function automatic logic [4:0] imm_width(input logic [4:0] major,
                                             input logic [2:0] sel);
        logic [4:0] w;
        w = `CID_W_RRI;
        case (major)
            `CID_OP_BRANCH: w = `CID_W_I;
            `CID_OP_ADDI:   w = `CID_W_RRIA;
            `CID_OP_LD, `CID_OP_SD: w = `CID_W_RRI;
            `CID_OP_SHIFT, `CID_OP_RRR, `CID_OP_RR, `CID_OP_JAL: w = `CID_W_NONE;
            `CID_OP_I8:     w = (sel == 3'h5 || sel == 3'h7) ? `CID_W_NONE : `CID_W_RI;
            `CID_OP_I64:    w = (sel == `CID_I64_ADD5 || sel == `CID_I64_ADDPC) ?
                                `CID_W_RRI : `CID_W_RI;
            `CID_OP_LWSP, `CID_OP_LWPC, `CID_OP_SWSP: w = `CID_W_RI;
            default: begin
                if (major < `CID_OP_LD || (major > `CID_OP_ADDI && major < `CID_OP_SD)) begin
                    w = `CID_W_RI;
                end
            end
        endcase
        return w;
    endfunction

    function automatic logic [15:0] low_mask(input logic [4:0] w);
        return 16'(({16'h0000, 16'hffff} << w) >> 16);
    endfunction

    state_type   state_q, state_d;
    logic [15:0] first_q, first_d;

    logic        valid_q, valid_d;
    group_type   group_q, group_d;
    logic [4:0]  major_q, major_d;
    logic [4:0]  minor_q, minor_d;
    logic [2:0]  r1_q, r1_d, r2_q, r2_d, r3_q, r3_d;
    logic [4:0]  full_q, full_d;
    logic [15:0] imm_q, imm_d;
    logic [4:0]  bits_q, bits_d;
    logic [5:0]  shamt_q, shamt_d;
    logic        ext_q, ext_d, is32_q, is32_d;
    logic [25:0] target_q, target_d;
    logic        xchg_q, xchg_d, rsv_q, rsv_d;

    logic        pfx;
    logic [2:0]  sel;

    always_comb begin
        pfx      = (state_q == ST_PREFIX);
        sel      = f.first_reg;
        state_d  = state_q;
        first_d  = first_q;
        valid_d  = 1'b0;
        group_d  = group_q;
        major_d  = major_q;
        minor_d  = minor_q;
        r1_d     = r1_q;
        r2_d     = r2_q;
        r3_d     = r3_q;
        full_d   = full_q;
        imm_d    = imm_q;
        bits_d   = bits_q;
        shamt_d  = shamt_q;
        ext_d    = ext_q;
        is32_d   = is32_q;
        target_d = target_q;
        xchg_d   = xchg_q;
        rsv_d    = rsv_q;
        if (i_valid) begin
            case (state_q)
                ST_JAL2: begin
                    // Second half of the long jump completes the target
                    valid_d  = 1'b1;
                    state_d  = ST_IDLE;
                    target_d = {first_q[4:0], first_q[9:5], i_half};
                end
                ST_IDLE, ST_PREFIX: begin
                    if (state_q == ST_IDLE && f.major == `CID_OP_PREFIX) begin
                        state_d = ST_PREFIX;
                        first_d = i_half;
                    end else if (state_q == ST_IDLE && f.major == `CID_OP_JAL) begin
                        state_d  = ST_JAL2;
                        first_d  = i_half;
                        group_d  = GRP_JAL;
                        major_d  = f.major;
                        minor_d  = 5'h00;
                        xchg_d   = i_half[10];
                        is32_d   = 1'b1;
                        ext_d    = 1'b0;
                        rsv_d    = 1'b0;
                        bits_d   = `CID_W_NONE;
                        imm_d    = 16'h0000;
                        shamt_d  = 6'h00;
                    end else begin
                        valid_d  = 1'b1;
                        state_d  = ST_IDLE;
                        major_d  = f.major;
                        r1_d     = f.first_reg;
                        r2_d     = f.second_reg_field;
                        r3_d     = f.third_reg_field;
                        full_d   = f.func5;
                        ext_d    = pfx;
                        is32_d   = pfx;
                        target_d = 26'h0000000;
                        xchg_d   = 1'b0;
                        rsv_d    = 1'b0;
                        shamt_d  = 6'h00;
                        minor_d  = {2'b00, sel};
                        bits_d   = imm_width(f.major, sel);
                        imm_d    = i_half & low_mask(bits_d);
                        // Prefix before a prefix or a long jump has no meaning
                        if (pfx && (f.major == `CID_OP_PREFIX || f.major == `CID_OP_JAL)) begin
                            rsv_d = 1'b1;
                        end
                        if (pfx) begin
                            bits_d = `CID_W_EXT;
                            imm_d  = {first_q[4:0], first_q[10:5], i_half[4:0]};
                        end
                        case (f.major)
                            `CID_OP_SHIFT: begin
                                group_d = GRP_SHIFT;
                                minor_d = {3'b000, f.func2};
                                bits_d  = `CID_W_NONE;
                                imm_d   = 16'h0000;
                                if (pfx) begin
                                    // Top count bit only for the doubleword left shift
                                    shamt_d = {(f.func2 == `CID_SH_DSLL) & first_q[5],
                                               first_q[10:6]};
                                end else begin
                                    // Count sits in bits 4:2; bits 10:8 name the register
                                    shamt_d = (f.third_reg_field == 3'h0) ? `CID_SHIFT_ZERO :
                                              {3'b000, f.third_reg_field};
                                end
                            end
                            `CID_OP_ADDI: begin
                                group_d = GRP_ADDI;
                                minor_d = {4'h0, i_half[4]};
                                if (pfx) begin
                                    bits_d = `CID_W_EXT_RRIA;
                                    imm_d  = {1'b0, first_q[3:0], first_q[10:4],
                                              i_half[3:0]};
                                end
                            end
                            `CID_OP_I8: begin
                                group_d = GRP_I8;
                                if (sel == `CID_I8_RSV0 || sel == `CID_I8_RSV1) begin
                                    rsv_d = 1'b1;
                                end
                            end
                            `CID_OP_RRR: begin
                                group_d = GRP_RRR;
                                minor_d = {3'b000, f.func2};
                                bits_d  = `CID_W_NONE;
                                imm_d   = 16'h0000;
                                rsv_d   = pfx;
                            end
                            `CID_OP_RR: begin
                                group_d = GRP_RR;
                                minor_d = f.func5;
                                bits_d  = `CID_W_NONE;
                                imm_d   = 16'h0000;
                                if (f.func5 == `CID_RR_RSV0 || f.func5 == `CID_RR_RSV1 ||
                                    f.func5 == `CID_RR_RSV2) begin
                                    rsv_d = 1'b1;
                                end
                                if (f.func5 == `CID_RR_JUMP &&
                                    !(f.second_reg_field == `CID_JR_RX ||
                                      f.second_reg_field == `CID_JALR_RA ||
                                      (f.second_reg_field == `CID_JR_RA &&
                                       f.first_reg == 3'h0))) begin
                                    rsv_d = 1'b1;
                                end
                                if (f.func5 == `CID_RR_DSRL || f.func5 == `CID_RR_DSRA) begin
                                    if (pfx) begin
                                        shamt_d = {first_q[5], first_q[10:6]};
                                    end else begin
                                        shamt_d = (f.first_reg == 3'h0) ? `CID_SHIFT_ZERO :
                                                  {3'b000, f.first_reg};
                                    end
                                end else if (pfx) begin
                                    rsv_d = 1'b1;
                                end
                            end
                            `CID_OP_I64: begin
                                group_d = GRP_I64;
                                if (!i_mode64) begin
                                    rsv_d = 1'b1;
                                end
                            end
                            default: group_d = GRP_OTHER;
                        endcase
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_q  <= ST_IDLE;
            first_q  <= 16'h0000;
            valid_q  <= 1'b0;
            group_q  <= GRP_OTHER;
            major_q  <= 5'h00;
            minor_q  <= 5'h00;
            r1_q     <= 3'h0;
            r2_q     <= 3'h0;
            r3_q     <= 3'h0;
            full_q   <= 5'h00;
            imm_q    <= 16'h0000;
            bits_q   <= 5'h00;
            shamt_q  <= 6'h00;
            ext_q    <= 1'b0;
            is32_q   <= 1'b0;
            target_q <= 26'h0000000;
            xchg_q   <= 1'b0;
            rsv_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            first_q  <= first_d;
            valid_q  <= valid_d;
            group_q  <= group_d;
            major_q  <= major_d;
            minor_q  <= minor_d;
            r1_q     <= r1_d;
            r2_q     <= r2_d;
            r3_q     <= r3_d;
            full_q   <= full_d;
            imm_q    <= imm_d;
            bits_q   <= bits_d;
            shamt_q  <= shamt_d;
            ext_q    <= ext_d;
            is32_q   <= is32_d;
            target_q <= target_d;
            xchg_q   <= xchg_d;
            rsv_q    <= rsv_d;
        end
    end

    assign o_valid                = valid_q;
    assign o_group                = group_q;
    assign o_major_code           = major_q;
    assign o_minor                = minor_q;
    assign o_first_reg            = r1_q;
    assign o_second_reg_field     = r2_q;
    assign o_third_reg_field      = r3_q;
    assign o_full_register_number = full_q;
    assign o_imm                  = imm_q;
    assign o_imm_bits             = bits_q;
    assign o_shamt                = shamt_q;
    assign o_extended             = ext_q;
    assign o_is32                 = is32_q;
    assign o_target               = target_q;
    assign o_exchange             = xchg_q;
    assign o_reserved             = rsv_q;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    chk_major_field: assert property (i_valid && state_q == ST_IDLE &&
        i_half[15:11] != `CID_OP_PREFIX && i_half[15:11] != `CID_OP_JAL
        |=> o_valid && o_major_code == $past(i_half[15:11])) else $error("major code lost");
    chk_jal_target: assert property (state_q == ST_JAL2 && i_valid
        |=> o_valid && o_is32 && o_target[15:0] == $past(i_half)) else $error("bad jump target");
    chk_jal_pair: assert property (i_valid && state_q == ST_IDLE &&
        i_half[15:11] == `CID_OP_JAL |=> !o_valid) else $error("jump half emitted early");
    chk_prefix_imm: assert property (state_q == ST_PREFIX && i_valid &&
        i_half[15:11] == `CID_OP_LD |=> o_extended && o_imm[4:0] == $past(i_half[4:0])
        && o_imm[15:11] == $past(first_q[4:0])) else $error("bad extended immediate");
    chk_shift_zero: assert property (state_q == ST_IDLE && i_valid &&
        i_half[15:11] == `CID_OP_SHIFT && i_half[4:2] == 3'h0
        |=> o_shamt == `CID_SHIFT_ZERO) else $error("zero shift not eight");
    chk_i8_reserved: assert property (i_valid && state_q == ST_IDLE &&
        i_half[15:11] == `CID_OP_I8 && i_half[10:8] == `CID_I8_RSV0
        |=> o_reserved) else $error("reserved code accepted");
    chk_i64_mode: assert property (o_valid && o_group == GRP_I64 &&
        !$past(i_mode64) |-> o_reserved) else $error("doubleword op outside 64-bit mode");
    chk_rrr_minor: assert property (o_valid && o_group == GRP_RRR
        |-> o_minor[4:2] == 3'b000 && o_imm_bits == `CID_W_NONE) else $error("bad rrr minor");
    chk_s5_gate: assert property (o_valid && o_group == GRP_SHIFT &&
        o_minor[1:0] != `CID_SH_DSLL |-> !o_shamt[5]) else $error("count top bit misused");
    cov_long_jump: cover property (o_valid && o_group == GRP_JAL && o_exchange);
    cov_ext_shift: cover property (o_valid && o_extended && o_group == GRP_RR);
    cov_reserved: cover property (o_valid && o_reserved);
endmodule

// File: dv/fetch_model.sv
/*
 * Behavioural fetch stage: hands halfwords to the decoder in program order.
 * Assumes the bench calls its tasks; drives just after the falling edge.
 */
`timescale 1ns/1ps

module fetch_model (
    input  wire logic        i_mclk,
    output logic             o_valid,
    output logic [15:0]      o_half
);
    initial begin
        o_valid = 1'b0;
        o_half  = 16'h0000;
    end

    // Each gap cycle inverts the half already on the bus, so stale data never decodes
    task automatic send(input logic [15:0] h, input int gap);
        repeat (gap) begin
            @(negedge i_mclk);
            o_valid = 1'b0;
            o_half  = ~o_half;
        end
        @(negedge i_mclk);
        o_valid = 1'b1;
        o_half  = h;
    endtask

    task automatic idle();
        @(negedge i_mclk);
        o_valid = 1'b0;
        o_half  = ~o_half;
    endtask
endmodule

// File: dv/compact_isa_decoder_tb.sv
/*
 * Self-checking bench: a queue model predicts every decoded instruction.
 * Assumes fetch_model as far side and the decoder's one-cycle latency.
 */
`timescale 1ns/1ps

module compact_isa_decoder_tb;
    import cid_pkg::*;
    typedef struct packed {
        logic [1:0] k; logic [3:0] g; logic [4:0] mj, mn, fr; logic [2:0] r1, r2, r3;
        logic [5:0] sh; logic rs; logic [15:0] im; logic [25:0] tg; logic x; logic [4:0] bw;
    } exp_type;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_mode64 = 1'b0, i_valid, o_valid, o_extended;
    logic o_is32, o_exchange, o_reserved;
    logic [15:0] i_half, o_imm, r, s;
    logic [4:0] o_major_code, o_minor, o_full_register_number, o_imm_bits;
    logic [2:0] o_first_reg, o_second_reg_field, o_third_reg_field;
    logic [5:0] o_shamt;
    logic [25:0] o_target;
    group_type o_group;
    int n_fail = 0, total_checks = 0, seed = 32'h0ae3e576;
    exp_type q[$], e;

    always #20 i_mclk = ~i_mclk;
    fetch_model fm (.i_mclk, .o_valid(i_valid), .o_half(i_half));
    compact_isa_decoder dut (.i_mclk, .i_rst_n, .i_valid, .i_half, .i_mode64, .o_valid,
        .o_group, .o_major_code, .o_minor, .o_first_reg, .o_second_reg_field,
        .o_third_reg_field, .o_full_register_number, .o_imm, .o_imm_bits, .o_shamt,
        .o_extended, .o_is32, .o_target, .o_exchange, .o_reserved);

    task automatic chk(input logic [25:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic exp_type predict(logic pf, logic [15:0] p, h, logic m);
        exp_type d = '0;
        logic [4:0] f = h[4:0];
        logic [2:0] rx = h[10:8];
        logic ds = h[15:11] == 5'h1d && (f == 5'h08 || f == 5'h13);
        d.k = {1'b0, pf};
        d.mj = h[15:11];
        d.mn = {2'h0, rx};
        d.fr = f;
        {d.r1, d.r2, d.r3} = h[10:2];
        d.im = d.mj == 5'h08 ? {1'h0, p[3:0], p[10:4], h[3:0]} : {p[4:0], p[10:5], f};
        case (d.mj)
            5'h06: begin
                d.g = 4'h2;
                d.mn = {3'h0, h[1:0]};
                d.sh = pf ? {p[5] & (h[1:0] == 2'h1), p[10:6]} : {2'h0, h[4:2] == 3'h0, h[4:2]};
            end
            5'h08: begin
                d.g = 4'h3;
                d.mn = {4'h0, h[4]};
            end
            5'h0c: begin
                d.g = 4'h4;
                d.rs = rx == 3'h4 || rx == 3'h6;
            end
            5'h1c: begin
                d.g = 4'h5;
                d.mn = {3'h0, h[1:0]};
                d.rs = pf;
            end
            5'h1d: begin
                d.g = 4'h6;
                d.mn = f;
                d.sh = !ds ? 6'h00 : pf ? {p[5], p[10:6]} : {2'h0, rx == 3'h0, rx};
                d.rs = (pf && !ds) || f == 5'h01 || f == 5'h11 || f == 5'h15 || (f == 5'h00
                    && !(h[7:5] == 3'h0 || h[7:5] == 3'h2 || (h[7:5] == 3'h1 && rx == 3'h0)));
            end
            5'h1f: begin
                d.g = 4'h7;
                d.rs = !m;
            end
            default: d.g = 4'h0;
        endcase
        // Unextended immediate width of each format
        case (d.mj)
            5'h02: d.bw = 5'h0b;
            5'h08: d.bw = 5'h04;
            5'h07, 5'h0f, 5'h10, 5'h11, 5'h13, 5'h14,
            5'h15, 5'h17, 5'h18, 5'h19, 5'h1b: d.bw = 5'h05;
            5'h03, 5'h06, 5'h1c, 5'h1d: d.bw = 5'h00;
            5'h0c: d.bw = rx[0] && rx[2] ? 5'h00 : 5'h08;
            5'h1f: d.bw = rx == 3'h5 || rx == 3'h6 ? 5'h05 : 5'h08;
            default: d.bw = 5'h08;
        endcase
        if (!pf) d.im = h & ~(16'hffff << d.bw);
        return d;
    endfunction

    // Mode changes at the negedge of the last half, so earlier instructions keep theirs
    task automatic issue(input logic pf, input logic [15:0] p, h, input logic m, input int gap);
        q.push_back(predict(pf, p, h, m));
        if (pf) fm.send(p, 0);
        fm.send(h, gap);
        i_mode64 = m;
    endtask

    always @(negedge i_mclk) if (o_valid === 1'b1) begin
        if (q.size() == 0) chk(26'h1, 26'h0);
        else begin
            e = q.pop_front();
            if (e.k != 2'h2) begin
                chk(o_group, e.g);
                chk(o_major_code, e.mj);
                chk(o_minor, e.mn);
                chk({o_first_reg, o_second_reg_field, o_third_reg_field}, {e.r1, e.r2, e.r3});
                chk(o_full_register_number, e.fr);
                chk(o_shamt, e.sh);
                chk({o_extended, o_is32}, {2{e.k[0]}});
            end else begin
                chk(o_target, e.tg);
                chk({o_exchange, o_is32, o_group}, {e.x, 1'h1, 4'h1});
            end
            if (e.k == 2'h1 && e.g != 4'h2 && e.g != 4'h5 && e.g != 4'h6)
                chk({o_imm_bits, o_imm}, {e.mj == 5'h08 ? 5'h0f : 5'h10, e.im});
            else if (e.k == 2'h0) chk({o_imm_bits, o_imm}, {e.bw, e.im});
            chk(o_reserved, e.rs);
        end
    end

    initial begin
        repeat (20000) @(posedge i_mclk);
        n_fail++;
        end_sim();
    end

    initial begin
        repeat (2) @(negedge i_mclk);
        i_rst_n = 1'b1;
        for (int i = 0; i < 32; i++) for (int j = 0; j < 4; j++) begin
            r = $random(seed);
            s = $random(seed);
            // Prefix S5 left clear here: only the doubleword left and right shifts may set it
            if (i != 3 && i != 30) issue(j[0], {5'h1e, s[10:6], 1'h0, s[4:0]}, {i[4:0], r[10:0]}, r[12], j);
        end
        $display("major map done");
        for (int i = 0; i < 32; i++) begin
            r = $random(seed);
            issue(1'h0, 16'h0000, {5'h1d, r[10:5], i[4:0]}, 1'h1, 0);
            issue(1'h0, 16'h0000, {5'h1d, 2'h0, i[3], i[2:0], 5'h00}, 1'h1, 0);
            if (i < 8) issue(1'h0, 16'h0000, {5'h0c, i[2:0], r[7:0]}, 1'h0, 0);
        end
        $display("minor maps done");
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            s = {5'h1e, i == 0 ? 5'h00 : r[15:11], (i == 1) & r[5], 5'h00};
            issue(1'h0, 16'h0000, {5'h06, r[10:5], 3'h0, i[1:0]}, 1'h0, 0);
            issue(1'h1, s, {5'h06, r[10:5], 3'h0, i[1:0]}, 1'h0, 0);
            issue(1'h1, s, {5'h1c, r[10:2], i[1:0]}, 1'h0, 0);
            issue(1'h1, s, {5'h1d, 3'h0, r[7:5], i[0] ? 5'h08 : 5'h13}, 1'h1, i);
            issue(1'h1, {5'h1e, r[10:0]}, {5'h08, r[10:5], i[0], r[3:0]}, 1'h0, 0);
            q.push_back('{k: 2'h2, tg: {r[4:0], r[9:5], s}, x: i[0], default: '0});
            fm.send({5'h03, i[0], r[9:0]}, 0);
            fm.send(s, i);
        end
        $display("extended forms done");
        // A reset between prefix and instruction must drop the pending prefix
        fm.send({5'h1e, r[10:0]}, 0);
        fm.idle();
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_mclk);
        i_rst_n = 1'b1;
        issue(1'h0, 16'h0000, {5'h08, r[10:0]}, 1'h0, 0);
        fm.idle();
        repeat (4) @(negedge i_mclk);
        chk(q.size(), 26'h0);
        $display("reset test done");
        end_sim();
    end
endmodule
